// ===== vclt_pkg.sv
package vclt_pkg;
    localparam logic [7:0] OFF_VENDOR_CAP = 8'h64;
    localparam logic [7:0] OFF_TEST_ROLE = 8'h68;
    localparam logic [7:0] OFF_TEST_TWO = 8'h6C;
    localparam logic [7:0] OFF_TIMER = 8'h70;
    localparam logic [7:0] CAP_ID_VAL = 8'h09;
    localparam logic [7:0] CAP_NEXT_VAL = 8'hB0;
    localparam logic [15:0] CAP_LEN_VAL = 16'h0034;
    localparam logic [31:0] TEST_ROLE_RST = 32'h04001060;
    localparam logic [31:0] TEST_TWO_RST = 32'h04000800;
    localparam int ROLE_CHG_EN_BIT = 1;
    localparam int HOT_RST_DIS_BIT = 2;
    localparam int DN_ROLE_BIT = 3;
    localparam int STRAP_LO_BIT = 13;
    localparam int STRAP_HI_BIT = 14;
    localparam int REPLAY_LO = 0;
    localparam int REPLAY_HI = 11;
    localparam int REPLAY_EN_BIT = 12;
    localparam int PM_DIS_BIT = 13;
    localparam int MSI_DIS_BIT = 14;
    localparam int ACK_LO = 16;
    localparam int ACK_HI = 29;
    localparam int ACK_EN_BIT = 30;
    localparam int VGA_BIT = 31;
    localparam logic [11:0] REPLAY_RST = 12'h000;
    localparam logic [13:0] ACK_RST = 14'h0000;
    localparam logic VGA_RST = 1'b1;
    // RW mask of timer word
    localparam logic [31:0] TIMER_RW_MASK = 32'h7FFF1FFF;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } vclt_cfg_req_t;

    typedef struct packed {
        logic [1:0] csr0_bits;
        logic [11:0] replay;
        logic replay_en;
        logic [13:0] ack;
        logic ack_en;
        logic vga;
        logic pm_dis;
        logic msi_dis;
    } vclt_strap_t;

    typedef enum logic [1:0] {
        VCLT_ROLE_UP = 2'b00,
        VCLT_ROLE_DN = 2'b01
    } vclt_role_t;
endpackage

// ===== vclt_timer_sel.sv
`timescale 1ns/10ps
// Picks user or internal timer value per enable
module vclt_timer_sel #(parameter int W = 12)
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic en_in,
    input wire logic [W-1:0] user_in,
    input wire logic [W-1:0] internal_in,
    output logic [W-1:0] value_out
);
    wire [W-1:0] sel_next = en_in ? user_in : internal_in;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            value_out <= '0;
        else if (ce_in)
            value_out <= sel_next;
    end
endmodule

// ===== vclt_regs.sv
`timescale 1ns/10ps
module vclt_regs
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire vclt_pkg::vclt_cfg_req_t cfg_req_in,
    input wire logic strap_load_in,
    input wire vclt_pkg::vclt_strap_t strap_in,
    input wire logic [11:0] int_replay_in,
    input wire logic [13:0] int_ack_in,
    input wire logic upstream_port_in,
    input wire logic up_link_down_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    output logic downstream_role_select_out,
    output logic role_change_en_out,
    output logic hot_reset_fire_out,
    output logic vga_decode_en_out,
    output logic pm_cap_dis_out,
    output logic msi_cap_dis_out,
    output logic [11:0] replay_timeout_out,
    output logic [13:0] ack_latency_out,
    output logic [31:0] test_two_out
);
    logic [31:0] role_reg;
    logic [31:0] two_reg;
    logic [31:0] timer_reg;
    logic [31:0] rdata_next;
    logic link_down_reg;
    logic role_reg_bit3;

    wire wr_role = cfg_req_in.wr && cfg_req_in.addr == vclt_pkg::OFF_TEST_ROLE;
    wire wr_two = cfg_req_in.wr && cfg_req_in.addr == vclt_pkg::OFF_TEST_TWO;
    wire wr_tmr = cfg_req_in.wr && cfg_req_in.addr == vclt_pkg::OFF_TIMER;

    function automatic logic [31:0] be_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be, input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
        return (old & ~bm) | (wd & bm);
    endfunction

    wire [31:0] cap_word = {vclt_pkg::CAP_LEN_VAL, vclt_pkg::CAP_NEXT_VAL,
        vclt_pkg::CAP_ID_VAL};

    wire [31:0] role_strap = {role_reg[31:vclt_pkg::STRAP_HI_BIT+1],
        strap_in.csr0_bits, role_reg[vclt_pkg::STRAP_LO_BIT-1:0]};

    wire [31:0] timer_strap = {strap_in.vga, strap_in.ack_en, strap_in.ack,
        1'b0, strap_in.msi_dis, strap_in.pm_dis, strap_in.replay_en,
        strap_in.replay};

    // Role bit only changes while the change enable is set
    wire [31:0] role_wr = be_merge(role_reg, cfg_req_in.wdata, cfg_req_in.be,
        32'hFFFFFFFF);
    wire role_bit_next = role_reg[vclt_pkg::ROLE_CHG_EN_BIT]
        ? role_wr[vclt_pkg::DN_ROLE_BIT]
        : role_reg[vclt_pkg::DN_ROLE_BIT];
    wire [31:0] role_wr_next = {role_wr[31:vclt_pkg::DN_ROLE_BIT+1],
        role_bit_next, role_wr[vclt_pkg::DN_ROLE_BIT-1:0]};

    // Named taps of the register fields
    wire role_dn_bit = role_reg[vclt_pkg::DN_ROLE_BIT];
    wire role_chg_bit = role_reg[vclt_pkg::ROLE_CHG_EN_BIT];
    wire replay_en_bit = timer_reg[vclt_pkg::REPLAY_EN_BIT];
    wire ack_en_bit = timer_reg[vclt_pkg::ACK_EN_BIT];
    wire [11:0] replay_user =
        timer_reg[vclt_pkg::REPLAY_HI:vclt_pkg::REPLAY_LO];
    wire [13:0] ack_user = timer_reg[vclt_pkg::ACK_HI:vclt_pkg::ACK_LO];
    wire take_cap = ce_in && cfg_req_in.rd
        && cfg_req_in.addr == vclt_pkg::OFF_VENDOR_CAP;
    wire plain_wr_tmr = ce_in && wr_tmr && !strap_load_in;
    wire plain_wr_role = ce_in && wr_role && !strap_load_in;
    wire hot_fire_next = upstream_port_in && up_link_down_in
        && !link_down_reg && !role_reg[vclt_pkg::HOT_RST_DIS_BIT];

    always_comb
    begin
        unique case (cfg_req_in.addr)
            vclt_pkg::OFF_VENDOR_CAP: rdata_next = cap_word;
            vclt_pkg::OFF_TEST_ROLE: rdata_next = role_reg;
            vclt_pkg::OFF_TEST_TWO: rdata_next = two_reg;
            vclt_pkg::OFF_TIMER: rdata_next = timer_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            role_reg <= vclt_pkg::TEST_ROLE_RST;
        else if (ce_in && strap_load_in)
            role_reg <= role_strap;
        else if (ce_in && wr_role)
            role_reg <= role_wr_next;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            two_reg <= vclt_pkg::TEST_TWO_RST;
        else if (ce_in && wr_two)
            two_reg <= be_merge(two_reg, cfg_req_in.wdata, cfg_req_in.be,
                32'hFFFFFFFF);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            timer_reg <= {vclt_pkg::VGA_RST, 1'b0, vclt_pkg::ACK_RST,
                4'h0, vclt_pkg::REPLAY_RST};
        else if (ce_in && strap_load_in)
            timer_reg <= timer_strap;
        else if (ce_in && wr_tmr)
            timer_reg <= be_merge(timer_reg, cfg_req_in.wdata, cfg_req_in.be,
                vclt_pkg::TIMER_RW_MASK);
    end

    // Read data, held until the next read; valid is high in the cycle after a read taken with ce_in high, and holds its value while ce_in is low
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 32'h00000000;
            rvalid_out <= 1'b0;
        end
        else if (ce_in)
        begin
            rdata_out <= cfg_req_in.rd ? rdata_next : rdata_out;
            rvalid_out <= cfg_req_in.rd;
        end
    end

    // Hot reset on link-down edge of an upstream port unless disabled
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            link_down_reg <= 1'b0;
            hot_reset_fire_out <= 1'b0;
        end
        else if (ce_in)
        begin
            link_down_reg <= up_link_down_in;
            hot_reset_fire_out <= hot_fire_next;
        end
    end

    // Link role controls
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            downstream_role_select_out <= 1'b0;
            role_change_en_out <= 1'b0;
        end
        else if (ce_in)
        begin
            downstream_role_select_out <= role_dn_bit;
            role_change_en_out <= role_chg_bit;
        end
    end

    // Capability and decode flags
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            vga_decode_en_out <= vclt_pkg::VGA_RST;
            pm_cap_dis_out <= 1'b0;
            msi_cap_dis_out <= 1'b0;
        end
        else if (ce_in)
        begin
            vga_decode_en_out <= timer_reg[vclt_pkg::VGA_BIT];
            pm_cap_dis_out <= timer_reg[vclt_pkg::PM_DIS_BIT];
            msi_cap_dis_out <= timer_reg[vclt_pkg::MSI_DIS_BIT];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            test_two_out <= vclt_pkg::TEST_TWO_RST;
        else if (ce_in)
            test_two_out <= two_reg;
    end

    vclt_timer_sel #(.W(12)) u_replay
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .en_in(timer_reg[vclt_pkg::REPLAY_EN_BIT]),
        .user_in(timer_reg[vclt_pkg::REPLAY_HI:vclt_pkg::REPLAY_LO]),
        .internal_in(int_replay_in),
        .value_out(replay_timeout_out)
    );

    vclt_timer_sel #(.W(14)) u_ack
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .en_in(timer_reg[vclt_pkg::ACK_EN_BIT]),
        .user_in(timer_reg[vclt_pkg::ACK_HI:vclt_pkg::ACK_LO]),
        .internal_in(int_ack_in),
        .value_out(ack_latency_out)
    );

    a_cap_word: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        take_cap |=> rdata_out == {vclt_pkg::CAP_LEN_VAL,
        vclt_pkg::CAP_NEXT_VAL, vclt_pkg::CAP_ID_VAL})
        else $error("capability header wrong");
    a_role_strap: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && strap_load_in
        |=> role_reg[vclt_pkg::STRAP_HI_BIT:vclt_pkg::STRAP_LO_BIT]
        == $past(strap_in.csr0_bits))
        else $error("role strap bits not loaded");
    a_role_keep: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && strap_load_in
        |=> role_reg[vclt_pkg::STRAP_LO_BIT-1:0]
        == $past(role_reg[vclt_pkg::STRAP_LO_BIT-1:0]))
        else $error("role bits changed by strap load");
    a_role_lock: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !strap_load_in && !role_chg_bit
        |=> role_dn_bit == $past(role_dn_bit))
        else $error("role changed while locked");
    a_role_unlock: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        plain_wr_role && role_chg_bit && cfg_req_in.be[0]
        |=> role_dn_bit == $past(cfg_req_in.wdata[vclt_pkg::DN_ROLE_BIT]))
        else $error("role write not taken");
    a_role_en: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in |=> role_change_en_out == $past(role_chg_bit))
        else $error("role change enable output mismatch");
    a_role_out: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in |=> downstream_role_select_out == $past(role_dn_bit))
        else $error("role output mismatch");
    a_hot_block: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && role_reg[vclt_pkg::HOT_RST_DIS_BIT] |=> !hot_reset_fire_out)
        else $error("hot reset fired while disabled");
    a_hot_fire: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && upstream_port_in && up_link_down_in && !link_down_reg
        && !role_reg[vclt_pkg::HOT_RST_DIS_BIT] |=> hot_reset_fire_out)
        else $error("hot reset not fired on link down");
    a_hot_pulse: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && hot_reset_fire_out |=> !hot_reset_fire_out)
        else $error("hot reset pulse too long");
    a_hot_up_only: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !upstream_port_in |=> !hot_reset_fire_out)
        else $error("hot reset fired on a non-upstream port");
    a_replay_sel: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && replay_en_bit
        |=> replay_timeout_out == $past(replay_user))
        else $error("replay user value not used");
    a_replay_int: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !replay_en_bit
        |=> replay_timeout_out == $past(int_replay_in))
        else $error("replay internal value not used");
    a_ack_sel: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && ack_en_bit
        |=> ack_latency_out == $past(ack_user))
        else $error("ack user value not used");
    a_ack_int: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && !ack_en_bit
        |=> ack_latency_out == $past(int_ack_in))
        else $error("ack internal value not used");
    a_vga_ro: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        plain_wr_tmr |=> $stable(timer_reg[vclt_pkg::VGA_BIT]))
        else $error("vga bit written");
    a_vga_out: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in |=> vga_decode_en_out == $past(timer_reg[vclt_pkg::VGA_BIT]))
        else $error("vga decode output mismatch");
    a_timer_wr: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        plain_wr_tmr && cfg_req_in.be == 4'hF
        |=> replay_user
        == $past(cfg_req_in.wdata[vclt_pkg::REPLAY_HI:vclt_pkg::REPLAY_LO])
        && ack_user == $past(cfg_req_in.wdata[vclt_pkg::ACK_HI:vclt_pkg::ACK_LO]))
        else $error("timer write lost");
    a_timer_strap: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && strap_load_in
        |=> replay_user == $past(strap_in.replay)
        && ack_user == $past(strap_in.ack)
        && replay_en_bit == $past(strap_in.replay_en)
        && ack_en_bit == $past(strap_in.ack_en))
        else $error("timer strap defaults not loaded");
    a_ce_freeze: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !ce_in |=> $stable(role_reg) && $stable(timer_reg)
        && $stable(rdata_out) && $stable(hot_reset_fire_out))
        else $error("state changed while clock enable low");
endmodule

// ===== vclt_host.sv
`timescale 1ns/10ps
// Upstream requester issuing config reads and writes
module vclt_host
(
    input wire logic clk_sys_in,
    input wire logic [31:0] rdata_in,
    input wire logic rvalid_in,
    output vclt_pkg::vclt_cfg_req_t req_out
);
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(posedge clk_sys_in);
        #1 req_out = {1'b1, 1'b0, a, b, d};
        @(posedge clk_sys_in);
        #1 req_out = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic v);
        @(posedge clk_sys_in);
        #1 req_out = {1'b0, 1'b1, a, 4'hF, 32'h00000000};
        @(posedge clk_sys_in);
        #1 req_out = '0;
        d = rdata_in;
        v = rvalid_in;
    endtask
endmodule

// ===== vclt_regs_test.sv
`timescale 1ns/10ps
module vclt_regs_test;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic sl = 1'b0;
    logic up = 1'b1;
    logic lnk = 1'b0;
    logic ce = 1'b1;
    vclt_pkg::vclt_strap_t st = '0;
    vclt_pkg::vclt_cfg_req_t req;
    logic [31:0] rdata, two, d;
    logic rv, dn, ren, fire, vga, pm, msi, v;
    logic [11:0] rep;
    logic [13:0] ack;
    int n_fail = 0;
    int check_count = 0;
    int i;
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    vclt_host vclt_host_inst (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
        .rvalid_in(rv), .req_out(req));
    vclt_regs vclt_regs_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .ce_in(ce), .cfg_req_in(req), .strap_load_in(sl), .strap_in(st),
        .int_replay_in(12'h5A5), .int_ack_in(14'h2C3D),
        .upstream_port_in(up), .up_link_down_in(lnk), .rdata_out(rdata),
        .rvalid_out(rv), .downstream_role_select_out(dn),
        .role_change_en_out(ren), .hot_reset_fire_out(fire),
        .vga_decode_en_out(vga), .pm_cap_dis_out(pm),
        .msi_cap_dis_out(msi), .replay_timeout_out(rep),
        .ack_latency_out(ack), .test_two_out(two));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        vclt_host_inst.rd(a, d, v);
        chk(32'(v), 32'h1);
        chk(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        vclt_host_inst.wr(a, 4'hF, x);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Link drop on the upstream side, watching for the reset pulse
    task automatic hot(input logic exp);
        logic seen;
        seen = 1'b0;
        lnk = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            idle(1);
            if (fire === 1'b1)
                seen = 1'b1;
        end
        lnk = 1'b0;
        idle(2);
        chk(32'(seen), 32'(exp));
        if (exp && !seen)
            report_and_stop();
    endtask
    initial
    begin
        idle(16);
        rst_in = 1'b0;
        rchk(8'h64, 32'h0034B009);
        rchk(8'h68, 32'h04001060);
        rchk(8'h70, 32'h80000000);
        chk(32'(vga), 32'h1);
        chk(32'(rep), 32'h5A5);
        $display("test reset done");
        wr(8'h64, 32'hFFFFFFFF);
        rchk(8'h64, 32'h0034B009);
        wr(8'h74, 32'hFFFFFFFF);
        rchk(8'h74, 32'h00000000);
        wr(8'h70, 32'hFFFFFFFF);
        rchk(8'h70, 32'hFFFF1FFF);
        chk(32'(rep), 32'hFFF);
        chk(32'(ack), 32'h3FFF);
        wr(8'h70, 32'h2ABC0123);
        rchk(8'h70, 32'hAABC0123);
        chk({rep, 6'h00, ack}, {12'h5A5, 6'h00, 14'h2C3D});
        vclt_host_inst.wr(8'h6C, 4'h1, 32'hFFFFFFFF);
        rchk(8'h6C, 32'h040008FF);
        chk(two, 32'h040008FF);
        $display("test access done");
        wr(8'h68, 32'h00000008);
        idle(1);
        chk(32'({dn, ren}), 32'h0);
        wr(8'h68, 32'h00000002);
        wr(8'h68, 32'h0000000A);
        idle(1);
        chk(32'({dn, ren}), 32'h3);
        hot(1'b1);
        wr(8'h68, 32'h00000006);
        idle(1);
        chk(32'(dn), 32'h0);
        hot(1'b0);
        up = 1'b0;
        wr(8'h68, 32'h00000002);
        hot(1'b0);
        $display("test role done");
        st = {2'b11, 12'h123, 1'b1, 14'h0456, 1'b0, 1'b0, 1'b1, 1'b1};
        sl = 1'b1;
        idle(1);
        sl = 1'b0;
        rchk(8'h70, 32'h04567123);
        rchk(8'h68, 32'h00006002);
        chk(32'(rep), 32'h123);
        chk(32'(ack), 32'h2C3D);
        chk(32'({vga, pm, msi}), 32'h3);
        $display("test strap done");
        ce = 1'b0;
        wr(8'h70, 32'h00000000);
        wr(8'h68, 32'h00000000);
        ce = 1'b1;
        rchk(8'h70, 32'h04567123);
        rchk(8'h68, 32'h00006002);
        $display("test enable done");
        rst_in = 1'b1;
        idle(2);
        rst_in = 1'b0;
        rchk(8'h68, 32'h04001060);
        rchk(8'h70, 32'h80000000);
        chk(32'({dn, ren, vga}), 32'h1);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
